//--- shared/nvm_pkg.sv
// constants and carrier types for the nonvolatile data access controller
// assumes a single cpu clock domain; the array is self timed by its own
// oscillator, whose ticks arrive as a plain pin
//
// Overview of operation
// RULE_01: a running write finishes in power-down; clock is then kept running.
// RULE_02: software should check no write is running before power-down.
// RULE_03: a running write completes across reset while supply stays good.
// RULE_04: nine bit linear byte address 0..511; high bits 15..9 read zero.
// RULE_05: software loads a valid address before access; reset content undefined.
// RULE_06: data register is write source and receives the byte on a read.
// RULE_07: control bits 7..4 are reserved and read as zero.
// RULE_08: ready interrupt is held while enabled, globally enabled, strobe zero.
// RULE_09: write starts only when strobe set within four cycles of master enable.
// RULE_10: strobe set with master enable zero does nothing.
// RULE_11: master enable clears itself four cycles after software sets it.
// RULE_12: software sets address, data, master enable, then strobe, in order.
// RULE_13: read strobe fetches the addressed byte into data register at once.
// RULE_14: every read stalls the cpu four cycles.
// RULE_15: software polls write strobe until zero before any access.
// RULE_16: bit set and clear in io 0x00..0x1f touch only the named bit.
// RULE_17: each io register also answers at io address plus 0x20 in data space.
// RULE_18: software writes reserved bits as zero, never writes reserved addresses.
// RULE_19: write strobe clears by hardware after the write; cpu stalls two cycles.
// RULE_20: each write is timed by 27072 oscillator cycles.
// RULE_21: during a write no read happens and the address is frozen; a reset_i during a running write still clears the address to 0.
// RULE_22: master enable window counts cpu cycles and restarts on a new set.
package nvm_pkg;

    // io addresses
    localparam logic [7:0] NVM_CONTROL_ADDR   = 8'h1f;
    localparam logic [7:0] NVM_DATA_ADDR      = 8'h20;
    localparam logic [7:0] NVM_ADDR_LOW_ADDR  = 8'h21;
    localparam logic [7:0] NVM_ADDR_HIGH_ADDR = 8'h22;
    localparam logic [7:0] IO_DATA_SPACE_OFS  = 8'h20;
    localparam logic [7:0] IO_SPACE_LAST      = 8'h3f;
    localparam logic [7:0] IO_BIT_OP_LAST     = 8'h1f;

    // control field positions
    localparam int CTL_READ_STROBE  = 0;
    localparam int CTL_WRITE_STROBE = 1;
    localparam int CTL_MASTER_WE    = 2;
    localparam int CTL_READY_IE     = 3;

    // geometry and reset values
    localparam int         NVM_ADDR_W     = 9;
    localparam logic [7:0] NVM_DATA_RESET = 8'h00;
    localparam logic [8:0] NVM_ADDR_RESET = 9'h000;

    // timing counts in cpu or oscillator cycles
    localparam logic [2:0] MWE_WINDOW_CYC   = 3'h4;
    localparam logic [2:0] READ_STALL_CYC   = 3'h4;
    localparam logic [2:0] WRITE_STALL_CYC  = 3'h2;
    localparam int         WRITE_OSC_CYCLES = 27072;

    typedef struct packed {
        logic [7:0] addr;
        logic       data_space;
        logic       wr;
        logic       rd;
        logic       bit_set;
        logic       bit_clr;
        logic [2:0] bit_idx;
        logic [7:0] wdata;
    } nvm_io_req_s;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } nvm_array_req_s;

endpackage

//--- logic/nvm_wtimer.sv
// self timed write period counter for the nonvolatile array
// assumes osc_tick_i is a one cycle pulse already synchronised to clock_i
`timescale 1ns/1ps
module nvm_wtimer #(
    parameter int OSC_CYCLES = nvm_pkg::WRITE_OSC_CYCLES
) (
    // clock and power-on reset only
    input  wire logic clock_i,
    input  wire logic por_i,
    // control
    input  wire logic start_i,
    input  wire logic osc_tick_i,
    // status
    output logic      busy_o,
    output logic      done_o
);
    localparam int CW = $clog2(OSC_CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(OSC_CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);

    logic [CW-1:0] count_ff;
    logic          busy_ff;
    logic          done_ff;
    wire           last_tick = busy_ff && osc_tick_i && (count_ff == ONE);

    // only power-on clears this, so a system reset leaves a write running
    always_ff @(posedge clock_i) begin                 // [RULE_03]
        if (por_i) begin
            count_ff <= '0;
            busy_ff  <= 1'b0;
            done_ff  <= 1'b0;
        end else begin
            done_ff <= last_tick;
            if (start_i && !busy_ff) begin
                count_ff <= LOAD;                  // [RULE_20]
                busy_ff  <= 1'b1;
            end else if (busy_ff && osc_tick_i) begin
                count_ff <= count_ff - ONE;        // [RULE_20]
                if (last_tick)
                    busy_ff <= 1'b0;               // [RULE_19]
            end
        end
    end

    assign busy_o = busy_ff;
    assign done_o = done_ff;
endmodule

//--- logic/nvm_access_ctrl.sv
// cpu side access logic for the 512 byte nonvolatile data array
// assumes the array read port is combinational from nvm_req_o.addr and
// that osc_tick_i comes from the array oscillator, unrelated to clock_i
`timescale 1ns/1ps
module nvm_access_ctrl #(
    parameter int OSC_CYCLES = nvm_pkg::WRITE_OSC_CYCLES
) (
    // clock and resets
    input  wire logic                  clock_i,
    input  wire logic                  reset_i,
    input  wire logic                  por_i,
    // cpu io port
    input  wire nvm_pkg::nvm_io_req_s  io_req_i,
    output logic [7:0]                 io_rdata_o,
    output logic                       stall_o,
    // core status and sleep
    input  wire logic                  global_ie_i,
    input  wire logic                  sleep_pd_i,
    output logic                       ready_irq_o,
    output logic                       osc_hold_o,
    // array side
    output nvm_pkg::nvm_array_req_s    nvm_req_o,
    input  wire logic [7:0]            nvm_rdata_i,
    input  wire logic                  osc_tick_i
);
    logic [8:0] addr_ff;
    logic [7:0] data_ff;
    logic [7:0] rdata_ff;
    logic       rie_ff;
    logic       mwe_ff;
    logic [2:0] mwe_cnt_ff;
    logic [2:0] stall_cnt_ff;
    logic       hold_ff;
    logic       tick_s1_ff;
    logic       tick_s2_ff;
    logic       tick_s3_ff;
    logic       busy;
    logic       wr_done;

    // address decode, io and data space views of the same registers
    wire [7:0] io_addr   = io_req_i.data_space ?
                           io_req_i.addr - nvm_pkg::IO_DATA_SPACE_OFS :
                           io_req_i.addr;
    wire       in_space  = io_req_i.data_space ?
        (io_req_i.addr >= nvm_pkg::IO_DATA_SPACE_OFS &&
         io_addr <= nvm_pkg::IO_SPACE_LAST) :
        (io_req_i.addr <= nvm_pkg::IO_SPACE_LAST);          // [RULE_17]
    wire       bit_op    = (io_req_i.bit_set || io_req_i.bit_clr) &&
                           !io_req_i.data_space &&
                           io_req_i.addr <= nvm_pkg::IO_BIT_OP_LAST;
    wire       sel_ctl   = in_space && io_addr == nvm_pkg::NVM_CONTROL_ADDR;
    wire       sel_data  = in_space && io_addr == nvm_pkg::NVM_DATA_ADDR;
    wire       sel_low   = in_space && io_addr == nvm_pkg::NVM_ADDR_LOW_ADDR;
    wire       sel_high  = in_space && io_addr == nvm_pkg::NVM_ADDR_HIGH_ADDR;
    wire       wr_any    = io_req_i.wr && !bit_op;

    // control value and the bits a write really touches
    wire [3:0] ctl_rd    = {rie_ff, mwe_ff, busy, 1'b0};
    wire [3:0] bit_mask  = io_req_i.bit_idx[2] ? 4'h0 :
                           4'(4'h1 << io_req_i.bit_idx[1:0]);
    wire [3:0] touched   = bit_op ? bit_mask : 4'hf;          // [RULE_16]
    wire [3:0] ctl_wval  = !bit_op ? io_req_i.wdata[3:0] :
                           io_req_i.bit_set ? (ctl_rd | bit_mask) :
                           (ctl_rd & ~bit_mask);
    wire       ctl_wr    = sel_ctl && (wr_any || bit_op);

    wire mwe_set  = ctl_wr && touched[nvm_pkg::CTL_MASTER_WE] &&
                    ctl_wval[nvm_pkg::CTL_MASTER_WE];
    wire mwe_clr  = ctl_wr && touched[nvm_pkg::CTL_MASTER_WE] &&
                    !ctl_wval[nvm_pkg::CTL_MASTER_WE];
    wire ws_try   = ctl_wr && touched[nvm_pkg::CTL_WRITE_STROBE] &&
                    ctl_wval[nvm_pkg::CTL_WRITE_STROBE];
    wire wr_go    = ws_try && mwe_ff && !busy;               // [RULE_09] [RULE_10]
    wire rd_go    = ctl_wr && touched[nvm_pkg::CTL_READ_STROBE] &&
                    ctl_wval[nvm_pkg::CTL_READ_STROBE] && !busy; // [RULE_21]
    wire addr_wr  = wr_any && !busy;                         // [RULE_21]
    wire tick     = tick_s2_ff && !tick_s3_ff;

    // oscillator tick crosses in through two flops before edge detection
    always_ff @(posedge clock_i) begin
        tick_s1_ff <= osc_tick_i;
        tick_s2_ff <= tick_s1_ff;
        tick_s3_ff <= tick_s2_ff;
    end

    nvm_wtimer #(
        .OSC_CYCLES (OSC_CYCLES)
    ) u_wtimer (
        .clock_i    (clock_i),
        .por_i      (por_i),
        .start_i    (wr_go),
        .osc_tick_i (tick),
        .busy_o     (busy),
        .done_o     (wr_done)
    );

    // address and data registers
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            addr_ff <= nvm_pkg::NVM_ADDR_RESET;
            data_ff <= nvm_pkg::NVM_DATA_RESET;
        end else begin
            if (addr_wr && sel_low)
                addr_ff[7:0] <= io_req_i.wdata;              // [RULE_04]
            if (addr_wr && sel_high)
                addr_ff[8] <= io_req_i.wdata[0];             // [RULE_04]
            if (rd_go)
                data_ff <= nvm_rdata_i;                      // [RULE_06] [RULE_13]
            else if (wr_any && sel_data)
                data_ff <= io_req_i.wdata;
        end
    end

    // master enable window, counted in cpu cycles
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mwe_ff     <= 1'b0;
            mwe_cnt_ff <= 3'h0;
            rie_ff     <= 1'b0;
        end else begin
            if (ctl_wr && touched[nvm_pkg::CTL_READY_IE])
                rie_ff <= ctl_wval[nvm_pkg::CTL_READY_IE];
            if (mwe_set) begin
                mwe_ff     <= 1'b1;                          // [RULE_22]
                mwe_cnt_ff <= nvm_pkg::MWE_WINDOW_CYC - 3'h1;
            end else if (mwe_clr || (mwe_ff && mwe_cnt_ff == 3'h0)) begin
                mwe_ff <= 1'b0;                              // [RULE_11]
            end else if (mwe_ff) begin
                mwe_cnt_ff <= mwe_cnt_ff - 3'h1;
            end
        end
    end

    // cpu stall and registered read data
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            stall_cnt_ff <= 3'h0;
            rdata_ff     <= 8'h00;
        end else begin
            if (rd_go)
                stall_cnt_ff <= nvm_pkg::READ_STALL_CYC;     // [RULE_14]
            else if (wr_go)
                stall_cnt_ff <= nvm_pkg::WRITE_STALL_CYC;    // [RULE_19]
            else if (stall_cnt_ff != 3'h0)
                stall_cnt_ff <= stall_cnt_ff - 3'h1;
            if (io_req_i.rd) begin
                rdata_ff <= sel_ctl  ? {4'h0, ctl_rd} :      // [RULE_07]
                            sel_data ? data_ff :
                            sel_low  ? addr_ff[7:0] :
                            sel_high ? {7'h00, addr_ff[8]} :  // [RULE_04]
                            8'h00;
            end
        end
    end

    // a write begun before power-down keeps the clock alive until wake
    always_ff @(posedge clock_i) begin
        if (por_i)
            hold_ff <= 1'b0;
        else
            hold_ff <= sleep_pd_i && (busy || hold_ff);      // [RULE_01]
    end

    assign io_rdata_o      = rdata_ff;
    assign stall_o         = stall_cnt_ff != 3'h0;
    assign ready_irq_o     = rie_ff && global_ie_i && !busy; // [RULE_08]
    assign osc_hold_o      = busy || hold_ff;                // [RULE_01]
    assign nvm_req_o.addr  = addr_ff;
    assign nvm_req_o.wdata = data_ff;                        // [RULE_06]
    assign nvm_req_o.we    = wr_go;
    assign nvm_req_o.re    = rd_go;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i || por_i);

    a_mwe_window_start: assert property (mwe_set |=> mwe_ff && // [RULE_22]
        mwe_cnt_ff == 3'h3) else $error("master enable window not armed");
    a_mwe_auto_clear: assert property (mwe_ff && mwe_cnt_ff == 3'h0 && // [RULE_11]
        !mwe_set |=> !mwe_ff) else $error("master enable did not expire");
    a_strobe_no_mwe: assert property (ws_try && !mwe_ff && !busy // [RULE_10]
        |=> !busy) else $error("write started without master enable");
    a_write_starts: assert property (ws_try && mwe_ff && !busy // [RULE_09]
        |=> busy && ctl_rd[1]) else $error("write did not start");
    a_read_stall_len: assert property (rd_go |=> stall_o[*4] // [RULE_14]
        ##1 !stall_o) else $error("read stall not four cycles");
    a_write_stall_len: assert property (wr_go |=> stall_o[*2] // [RULE_19]
        ##1 !stall_o) else $error("write stall not two cycles");
    a_read_data_load: assert property (rd_go |=> // [RULE_13]
        data_ff == $past(nvm_rdata_i)) else $error("read byte not loaded");
    a_addr_frozen: assert property (busy |=> $stable(addr_ff)) // [RULE_21]
        else $error("address changed during write");
    a_ready_irq_level: assert property (busy |-> !ready_irq_o) // [RULE_08]
        else $error("ready interrupt while write runs");
    a_ctl_reserved_zero: assert property (io_req_i.rd && sel_ctl // [RULE_07]
        |=> io_rdata_o[7:4] == 4'h0) else $error("reserved bits not zero");
    a_high_addr_zero: assert property (io_req_i.rd && sel_high // [RULE_04]
        |=> io_rdata_o[7:1] == 7'h00) else $error("high address bits set");
    a_pd_hold_clock: assert property (busy && sleep_pd_i // [RULE_01]
        |=> osc_hold_o) else $error("clock released during pd write");
    a_reset_keeps_write: assert property (@(posedge clock_i) // [RULE_03]
        disable iff (por_i) reset_i && busy && !tick |=> busy)
        else $error("reset aborted a running write");

    c_write_start: cover property (wr_go);
    c_read_done: cover property (rd_go ##1 stall_o[*4]);
    c_write_done: cover property (wr_done ##1 ready_irq_o);
endmodule

//--- verif/nvm_array_model.sv
// behavioural model of the 512 byte array and its own oscillator
// assumes we pulses last one cpu cycle; erased cells read as ff
`timescale 1ns/1ps
module nvm_array_model (
    // cpu clock
    input  wire logic                    clock_i,
    // request from controller
    input  wire nvm_pkg::nvm_array_req_s req_i,
    // answers
    output logic [7:0]                   rdata_o,
    output logic                         osc_tick_o
);
    logic [7:0] mem [0:511];

    // oscillator free running, unrelated in phase to the cpu clock
    initial begin
        foreach (mem[i]) begin
            mem[i] = 8'hff;
        end
        osc_tick_o = 1'b0;
        forever #7 osc_tick_o = ~osc_tick_o;
    end

    assign rdata_o = mem[req_i.addr];

    always @(posedge clock_i) begin
        if (req_i.we === 1'b1) begin
            mem[req_i.addr] <= req_i.wdata;
        end
    end
endmodule

//--- verif/tb.sv
// self checking bench for the nonvolatile access controller
// assumes the array model answers reads in the same cycle
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] CTL  = nvm_pkg::NVM_CONTROL_ADDR;
    localparam logic [7:0] DAT  = nvm_pkg::NVM_DATA_ADDR;
    localparam logic [7:0] LOW  = nvm_pkg::NVM_ADDR_LOW_ADDR;
    localparam logic [7:0] HIGH = nvm_pkg::NVM_ADDR_HIGH_ADDR;
    logic                    clock_i;
    logic                    reset_i;
    logic                    por_i;
    logic                    gie;
    logic                    sleep_pd;
    logic                    stall;
    logic                    irq;
    logic                    hold;
    logic                    tick;
    logic [7:0]              rdata;
    logic [7:0]              ardata;
    logic [7:0]              rv;
    nvm_pkg::nvm_io_req_s    req;
    nvm_pkg::nvm_array_req_s areq;
    int                      n_fail = 0;
    int                      tests_run = 0;
    int                      st;

    nvm_access_ctrl #(.OSC_CYCLES(8)) dut_u (
        .clock_i(clock_i), .reset_i(reset_i), .por_i(por_i),
        .io_req_i(req), .io_rdata_o(rdata), .stall_o(stall),
        .global_ie_i(gie), .sleep_pd_i(sleep_pd), .ready_irq_o(irq),
        .osc_hold_o(hold), .nvm_req_o(areq), .nvm_rdata_i(ardata),
        .osc_tick_i(tick));
    nvm_array_model mdl_u (.clock_i(clock_i), .req_i(areq),
        .rdata_o(ardata), .osc_tick_o(tick));

    initial begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // kind 0 write, 1 read, 2 bit set, 3 bit clear; entered at a negedge
    task automatic acc(input logic [7:0] a, input int kind,
                       input logic [7:0] d);
        req.addr = a;
        req.data_space = (a > 8'h3f);
        req.wr = (kind == 0);
        req.rd = (kind == 1);
        req.bit_set = (kind == 2);
        req.bit_clr = (kind == 3);
        req.bit_idx = d[2:0];
        req.wdata = d;
        @(negedge clock_i);
        req = '0;
        rv = rdata;
        st = 0;
        while (stall === 1'b1 && st < 20) begin
            st++;
            @(negedge clock_i);
        end
    endtask

    // polls the write strobe bit, bounded
    task automatic wait_idle();
        int k = 0;
        rv = 8'h02;
        while (rv[1] !== 1'b0 && k < 100) begin
            k++;
            acc(CTL, 1, 8'h00);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #20000;
        n_fail++;
        summarize();
    end

    initial begin
        req = '0;
        reset_i = 1'b1;
        por_i = 1'b1;
        gie = 1'b0;
        sleep_pd = 1'b0;
        repeat (12) @(posedge clock_i);
        @(negedge clock_i);
        reset_i = 1'b0;
        por_i = 1'b0;
        acc(CTL, 1, 8'h00);
        chk(rv, 8'h00);
        acc(DAT, 1, 8'h00);
        chk(rv, nvm_pkg::NVM_DATA_RESET);
        acc(8'h23, 1, 8'h00);
        chk(rv, 8'h00); // unmapped
        acc(8'h40, 0, 8'h5a);
        acc(DAT, 1, 8'h00);
        chk(rv, 8'h5a);
        acc(HIGH, 0, 8'h01);
        acc(HIGH, 1, 8'h00);
        chk(rv, 8'h01);
        acc(LOW, 0, 8'ha5);
        acc(DAT, 0, 8'h3c);
        acc(CTL, 2, 8'h03);
        acc(CTL, 1, 8'h00);
        chk(rv, 8'h08);
        gie = 1'b1;
        @(negedge clock_i);
        chk({7'h00, irq}, 8'h01);
        acc(CTL, 2, 8'h02);
        acc(CTL, 2, 8'h01);
        chk(8'(st), 8'h02);
        chk({7'h00, irq}, 8'h00);
        acc(LOW, 0, 8'h00);
        acc(CTL, 2, 8'h00);
        chk(8'(st), 8'h00);
        wait_idle();
        chk(rv, 8'h08);
        acc(LOW, 1, 8'h00);
        chk(rv, 8'ha5);
        acc(CTL, 2, 8'h00);
        chk(8'(st), 8'h04);
        acc(DAT, 1, 8'h00);
        chk(rv, 8'h3c);
        acc(DAT, 0, 8'h77);
        acc(CTL, 2, 8'h01);
        chk(8'(st), 8'h00);
        acc(CTL, 2, 8'h02);
        repeat (4) @(negedge clock_i);
        acc(CTL, 2, 8'h01);
        chk(8'(st), 8'h00);
        acc(CTL, 2, 8'h00);
        acc(DAT, 1, 8'h00);
        chk(rv, 8'h3c);
        acc(DAT, 0, 8'h77);
        acc(CTL, 2, 8'h02);
        repeat (2) @(negedge clock_i);
        acc(CTL, 2, 8'h02);
        repeat (2) @(negedge clock_i);
        acc(CTL, 2, 8'h01);
        chk(8'(st), 8'h02);
        // reset and power-down both arrive while the write runs
        sleep_pd = 1'b1;
        reset_i = 1'b1;
        @(negedge clock_i);
        reset_i = 1'b0;
        acc(CTL, 1, 8'h00);
        chk(rv, 8'h02);
        wait_idle();
        chk({7'h00, hold}, 8'h01);
        sleep_pd = 1'b0;
        @(negedge clock_i);
        chk({7'h00, hold}, 8'h00);
        acc(HIGH, 0, 8'h01);
        acc(LOW, 0, 8'ha5);
        acc(CTL, 2, 8'h00);
        acc(DAT, 1, 8'h00);
        chk(rv, 8'h77);
        acc(CTL, 2, 8'h03);
        acc(CTL, 3, 8'h03);
        acc(CTL, 1, 8'h00);
        chk(rv, 8'h00);
        summarize();
    end
endmodule
